// *** rtl/dam_decoder.sv ***
// Notes on behaviour
// - The instruction space is 64K addresses of 32-bit words, populated per product.
// - Instruction addresses 0x200 to 0x23F are the vector region, four words per source.
// - Reset enters through the vector region like an interrupt, at 0x200.
// - Data has two independent spaces, X and Y, each 64K addresses of 16-bit words.
// - Peripheral registers sit at 0x3800 to 0x3808 in internal data space.
// - A peripheral address reaches the same register from X as from Y.
// - After reset release and boot, execution starts from the reset entry at 0x200.
`timescale 1ns/1ps
module dam_decoder import dam_pkg::*; #(
  parameter logic [15:0] LOW_RAM_LAST = LOW_RAM_LAST_DEF,
  parameter logic [15:0] HIGH_MEM_FIRST = HIGH_MEM_FIRST_DEF,
  parameter logic [15:0] HIGH_MEM_LAST = HIGH_MEM_LAST_DEF
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Boot handshake and start of execution.
  input wire logic boot_done,
  output logic exec_start,
  output logic [15:0] exec_addr,
  // Event sources; the external ones are pins.
  input wire logic external_irq_one,
  input wire logic external_irq_two,
  input wire logic external_irq_three,
  input wire logic external_irq_four,
  input wire logic serial_one_rx,
  input wire logic serial_one_tx,
  input wire logic serial_two_rx,
  input wire logic serial_two_tx,
  input wire logic host_rx,
  input wire logic host_tx,
  output logic vector_valid,
  output logic [15:0] vector_addr,
  // Instruction fetch.
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic imem_req,
  output logic [2:0] imem_region,
  output logic [15:0] imem_addr,
  output logic fetch_reserved,
  // X data space, core side.
  input wire logic x_req,
  input wire logic x_we,
  input wire logic [15:0] x_addr,
  input wire logic [15:0] x_wdata,
  output logic x_rvalid,
  output logic [15:0] x_rdata,
  // X data space, memory side.
  output logic x_mem_req,
  output logic x_mem_we,
  output logic [15:0] x_mem_addr,
  output logic [15:0] x_mem_wdata,
  input wire logic [15:0] x_mem_rdata,
  // Y data space, core side.
  input wire logic y_req,
  input wire logic y_we,
  input wire logic [15:0] y_addr,
  input wire logic [15:0] y_wdata,
  output logic y_rvalid,
  output logic [15:0] y_rdata,
  // Y data space, memory side.
  output logic y_mem_req,
  output logic y_mem_we,
  output logic [15:0] y_mem_addr,
  output logic [15:0] y_mem_wdata,
  input wire logic [15:0] y_mem_rdata,
  // Shared peripheral register port.
  output logic [7:0] periph_sel,
  output logic periph_we,
  output logic [15:0] periph_wdata,
  input wire logic [127:0] periph_rdata,
  // Status.
  output logic [15:0] data_wait_cycles,
  output logic data_reserved,
  output logic periph_collision
);

  if (LOW_RAM_LAST <= VEC_LAST || HIGH_MEM_FIRST > HIGH_MEM_LAST ||
      HIGH_MEM_FIRST <= LOW_RAM_LAST) begin : g_bad_map
    $error("dam_decoder: instruction memory bounds overlap or are inverted");
  end

  function automatic dam_iregion_e iregion(input logic [15:0] a);
    if (a <= BOOT_ROM_LAST) begin
      return IR_BOOT_ROM;
    end else if (a >= VEC_BASE && a <= VEC_LAST) begin
      return IR_VECTOR;
    end else if (a > VEC_LAST && a <= LOW_RAM_LAST) begin
      return IR_INT_RAM;
    end else if (a >= HIGH_MEM_FIRST && a <= HIGH_MEM_LAST) begin
      return IR_HIGH_MEM;
    end else begin
      return IR_SYSTEM;
    end
  endfunction : iregion

  function automatic dam_dregion_e dregion(input logic [15:0] a);
    if (a >= PERIPH_BASE && a <= DATA_WAIT_CYCLES_ADDR) begin
      return DR_PERIPH;
    end else if (a > DATA_WAIT_CYCLES_ADDR && a <= PERIPH_LAST) begin
      return DR_RESERVED;
    end else begin
      return DR_MEMORY;
    end
  endfunction : dregion

  // Start of execution after boot.
  dam_state_e state;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_BOOT;
      exec_start <= 1'b0;
      exec_addr <= RESET_ENTRY;
    end else begin
      exec_start <= 1'b0;
      case (state)
        ST_BOOT: begin
          if (boot_done) begin
            state <= ST_RUN;
            exec_start <= 1'b1;
            exec_addr <= RESET_ENTRY;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_BOOT;
        end
      endcase
    end
  end

  // External lines are asynchronous, so they pass two flip-flops first.
  logic [3:0] irq_meta;
  logic [3:0] irq_sync;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_meta <= 4'h0;
      irq_sync <= 4'h0;
    end else begin
      irq_meta <= {external_irq_four, external_irq_three, external_irq_two, external_irq_one};
      irq_sync <= irq_meta;
    end
  end

  // Events are held back until boot has finished so the first entry is always reset.
  logic [NUM_EVENTS-1:0] event_req;

  always_comb begin
    event_req = {host_tx, host_rx, serial_two_tx, serial_two_rx,
                 serial_one_tx, serial_one_rx, irq_sync};
    if (state != ST_RUN) begin
      event_req = '0;
    end
  end

  dam_vector_encoder #(
    .N_EVENTS(NUM_EVENTS)
  ) u_vector (
    .ref_clk(ref_clk),
    .srst(srst),
    .event_req(event_req),
    .vector_valid(vector_valid),
    .vector_addr(vector_addr)
  );

  // Instruction fetch decode; reserved addresses are flagged, never forwarded.
  dam_iregion_e fetch_region;

  always_comb begin
    fetch_region = iregion(fetch_addr);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      imem_req <= 1'b0;
      imem_region <= IR_SYSTEM;
      imem_addr <= 16'h0000;
      fetch_reserved <= 1'b0;
    end else begin
      imem_req <= fetch_req && fetch_region != IR_SYSTEM;
      imem_region <= fetch_region;
      imem_addr <= fetch_addr;
      fetch_reserved <= fetch_req && fetch_region == IR_SYSTEM;
    end
  end

  // Data spaces: index 0 is X, index 1 is Y.
  logic req [2];
  logic we [2];
  logic [15:0] addr [2];
  logic [15:0] wdata [2];
  logic [15:0] mem_rdata [2];
  logic hit [2];
  logic resv [2];
  logic mem_req_q [2];
  logic mem_we_q [2];
  logic [15:0] mem_addr_q [2];
  logic [15:0] mem_wdata_q [2];
  logic rd_pend [2];
  dam_dregion_e rd_src [2];
  logic rvalid_q [2];
  logic [15:0] rdata_q [2];

  assign req[0] = x_req;
  assign req[1] = y_req;
  assign we[0] = x_we;
  assign we[1] = y_we;
  assign addr[0] = x_addr;
  assign addr[1] = y_addr;
  assign wdata[0] = x_wdata;
  assign wdata[1] = y_wdata;
  assign mem_rdata[0] = x_mem_rdata;
  assign mem_rdata[1] = y_mem_rdata;

  // One shared register port serves both spaces; X is served when both collide.
  logic grant_y;
  logic p_valid;
  logic p_owner;
  logic [3:0] p_idx;
  logic [15:0] p_rdata;

  assign grant_y = hit[1] && !hit[0];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p_valid <= 1'b0;
      p_owner <= 1'b0;
      p_idx <= 4'h0;
      periph_sel <= 8'h00;
      periph_we <= 1'b0;
      periph_wdata <= 16'h0000;
      periph_collision <= 1'b0;
      data_reserved <= 1'b0;
    end else begin
      p_valid <= hit[0] || hit[1];
      p_owner <= grant_y;
      p_idx <= grant_y ? addr[1][3:0] : addr[0][3:0];
      periph_sel <= 8'h00;
      if ((hit[0] || hit[1]) && (grant_y ? addr[1][3] : addr[0][3]) == 1'b0) begin
        periph_sel <= 8'h01 << (grant_y ? addr[1][2:0] : addr[0][2:0]);
      end
      periph_we <= grant_y ? we[1] : (hit[0] && we[0]);
      periph_wdata <= grant_y ? wdata[1] : wdata[0];
      periph_collision <= hit[0] && hit[1];
      data_reserved <= resv[0] || resv[1];
    end
  end

  // The wait-cycle register lives here since no peripheral unit owns it.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_wait_cycles <= DATA_WAIT_CYCLES_RESET;
    end else if (p_valid && periph_we && p_idx == WAIT_REG_INDEX) begin
      data_wait_cycles <= periph_wdata;
    end
  end

  always_comb begin
    p_rdata = 16'h0000;
    if (p_idx == WAIT_REG_INDEX) begin
      p_rdata = data_wait_cycles;
    end else if (p_idx[3] == 1'b0) begin
      p_rdata = periph_rdata[16 * p_idx[2:0] +: 16];
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_space
    dam_dregion_e region;

    always_comb begin
      region = dregion(addr[s]);
    end

    assign hit[s] = req[s] && region == DR_PERIPH;
    assign resv[s] = req[s] && region == DR_RESERVED;

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        mem_req_q[s] <= 1'b0;
        mem_we_q[s] <= 1'b0;
        mem_addr_q[s] <= 16'h0000;
        mem_wdata_q[s] <= 16'h0000;
        rd_pend[s] <= 1'b0;
        rd_src[s] <= DR_MEMORY;
      end else begin
        mem_req_q[s] <= req[s] && region == DR_MEMORY;
        mem_we_q[s] <= we[s];
        mem_addr_q[s] <= addr[s];
        mem_wdata_q[s] <= wdata[s];
        rd_pend[s] <= req[s] && !we[s];
        // A losing Y access is answered like a reserved one, with zero.
        if (s == 1 && hit[0] && hit[1]) begin
          rd_src[s] <= DR_RESERVED;
        end else begin
          rd_src[s] <= region;
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        rvalid_q[s] <= 1'b0;
        rdata_q[s] <= 16'h0000;
      end else begin
        rvalid_q[s] <= rd_pend[s];
        case (rd_src[s])
          DR_MEMORY: rdata_q[s] <= mem_rdata[s];
          DR_PERIPH: rdata_q[s] <= (p_owner == (s == 1)) ? p_rdata : 16'h0000;
          default: rdata_q[s] <= 16'h0000;
        endcase
      end
    end
  end

  assign x_mem_req = mem_req_q[0];
  assign x_mem_we = mem_we_q[0];
  assign x_mem_addr = mem_addr_q[0];
  assign x_mem_wdata = mem_wdata_q[0];
  assign y_mem_req = mem_req_q[1];
  assign y_mem_we = mem_we_q[1];
  assign y_mem_addr = mem_addr_q[1];
  assign y_mem_wdata = mem_wdata_q[1];
  assign x_rvalid = rvalid_q[0];
  assign x_rdata = rdata_q[0];
  assign y_rvalid = rvalid_q[1];
  assign y_rdata = rdata_q[1];

endmodule : dam_decoder

// *** rtl/dam_pkg.sv ***
package dam_pkg;

  // Word widths of the two address spaces.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned IWORD_W = 32;
  localparam int unsigned DWORD_W = 16;

  // Instruction space landmarks.
  localparam logic [15:0] BOOT_ROM_LAST = 16'h00FF;
  localparam logic [15:0] VEC_BASE = 16'h0200;
  localparam logic [15:0] VEC_LAST = 16'h023F;
  localparam logic [15:0] RESET_ENTRY = 16'h0200;
  localparam logic [15:0] VEC_SLOT_STEP = 16'h0004;
  localparam logic [15:0] VEC_SRC_FIRST = 16'h0210;
  localparam int unsigned NUM_EVENTS = 10;
  localparam logic [15:0] LOW_RAM_LAST_DEF = 16'h0FFF;
  localparam logic [15:0] HIGH_MEM_FIRST_DEF = 16'h4000;
  localparam logic [15:0] HIGH_MEM_LAST_DEF = 16'hBFFF;

  // Peripheral window in both data spaces.
  localparam logic [15:0] PERIPH_BASE = 16'h3800;
  localparam logic [15:0] PERIPH_LAST = 16'h383F;
  localparam logic [15:0] SERIAL_ONE_DATA_ADDR = 16'h3800;
  localparam logic [15:0] SERIAL_ONE_STATUS_ADDR = 16'h3801;
  localparam logic [15:0] SERIAL_TWO_DATA_ADDR = 16'h3802;
  localparam logic [15:0] SERIAL_TWO_STATUS_ADDR = 16'h3803;
  localparam logic [15:0] PORT_PIN_DATA_ADDR = 16'h3804;
  localparam logic [15:0] PORT_COMMAND_ADDR = 16'h3805;
  localparam logic [15:0] HOST_LINK_DATA_ADDR = 16'h3806;
  localparam logic [15:0] HOST_LINK_STATUS_ADDR = 16'h3807;
  localparam logic [15:0] DATA_WAIT_CYCLES_ADDR = 16'h3808;
  localparam int unsigned PERIPH_EXT_COUNT = 8;
  localparam logic [3:0] WAIT_REG_INDEX = 4'h8;
  localparam logic [15:0] DATA_WAIT_CYCLES_RESET = 16'h0000;

  typedef enum logic [2:0] {
    IR_BOOT_ROM = 3'b000,
    IR_SYSTEM = 3'b001,
    IR_VECTOR = 3'b010,
    IR_INT_RAM = 3'b011,
    IR_HIGH_MEM = 3'b100
  } dam_iregion_e;

  typedef enum logic [1:0] {
    DR_MEMORY = 2'b00,
    DR_PERIPH = 2'b01,
    DR_RESERVED = 2'b10
  } dam_dregion_e;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN = 2'b01
  } dam_state_e;

endpackage : dam_pkg

// *** rtl/dam_vector_encoder.sv ***
`timescale 1ns/1ps
module dam_vector_encoder import dam_pkg::*; #(
  parameter int unsigned N_EVENTS = NUM_EVENTS
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Pending event sources, lowest index wins.
  input wire logic [N_EVENTS-1:0] event_req,
  // Selected entry point.
  output logic vector_valid,
  output logic [15:0] vector_addr
);

  if (32'(VEC_SRC_FIRST) + 4 * N_EVENTS - 1 > 32'(VEC_LAST)) begin : g_bad_count
    $error("dam_vector_encoder: event slots overrun the vector region");
  end

  logic next_valid;
  logic [15:0] next_addr;

  // Walking downward lets the lowest-numbered source overwrite the others.
  always_comb begin
    next_valid = 1'b0;
    next_addr = RESET_ENTRY;
    for (int i = N_EVENTS - 1; i >= 0; i--) begin
      if (event_req[i]) begin
        next_valid = 1'b1;
        next_addr = VEC_SRC_FIRST + (16'(i) << 2);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vector_valid <= 1'b0;
      vector_addr <= RESET_ENTRY;
    end else begin
      vector_valid <= next_valid;
      vector_addr <= next_addr;
    end
  end

endmodule : dam_vector_encoder

// *** verification/dam_decoder_chk.sv ***
`timescale 1ns/1ps
module dam_decoder_chk import dam_pkg::*; (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Boot, vectors and fetch.
  input wire logic boot_done,
  input wire logic exec_start,
  input wire logic [15:0] exec_addr,
  input wire logic serial_one_rx,
  input wire logic vector_valid,
  input wire logic [15:0] vector_addr,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic imem_req,
  input wire logic [2:0] imem_region,
  input wire logic fetch_reserved,
  input wire logic [15:0] imem_addr,
  // Data spaces.
  input wire logic x_req,
  input wire logic x_we,
  input wire logic [15:0] x_addr,
  input wire logic [15:0] x_wdata,
  input wire logic y_req,
  input wire logic y_we,
  input wire logic [15:0] y_addr,
  input wire logic [15:0] y_wdata,
  input wire logic x_mem_req,
  input wire logic x_mem_we,
  input wire logic [15:0] x_mem_addr,
  input wire logic [15:0] x_mem_wdata,
  input wire logic y_mem_req,
  input wire logic y_mem_we,
  input wire logic [15:0] y_mem_addr,
  input wire logic [15:0] y_mem_wdata,
  input wire logic [7:0] periph_sel,
  input wire logic periph_we,
  input wire logic [15:0] periph_wdata,
  input wire logic data_reserved,
  input wire logic periph_collision
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_EXEC_ADDR: assert property (exec_start |-> exec_addr == 16'h0200)
    else $error("start address wrong");
  AST_BOOT_FIRST: assert property (exec_start |-> $past(boot_done))
    else $error("start without boot done");
  AST_START_PULSE: assert property (exec_start |=> !exec_start)
    else $error("start pulse longer than one cycle");
  AST_VEC_SLOT: assert property (vector_valid |-> vector_addr[1:0] == 2'h0 &&
    vector_addr >= 16'h0210 && vector_addr <= 16'h0234) else $error("vector outside slots");
  AST_VEC_S1RX: assert property (vector_valid && vector_addr == 16'h0220
    |-> $past(serial_one_rx)) else $error("serial one vector without cause");
  AST_FETCH_VEC: assert property (fetch_req && fetch_addr >= 16'h0200 &&
    fetch_addr <= 16'h023F |=> imem_req && imem_region == 3'h2) else $error("vector fetch");
  AST_FETCH_SYS: assert property (fetch_req && fetch_addr[15:8] == 8'h01
    |=> fetch_reserved && !imem_req) else $error("system fetch forwarded");
  AST_FETCH_ADDR: assert property (fetch_req |=> imem_addr == $past(fetch_addr))
    else $error("fetch address not forwarded");
  AST_X_PERIPH: assert property (x_req && x_addr == 16'h3801 |=> periph_sel == 8'h02)
    else $error("x peripheral select");
  AST_Y_PERIPH: assert property (y_req && !x_req && y_addr == 16'h3805
    |=> periph_sel == 8'h20) else $error("y peripheral select");
  AST_P_WR: assert property (x_req && x_we && x_addr == 16'h3808
    |=> periph_we && periph_sel == 8'h00 && periph_wdata == $past(x_wdata))
    else $error("wait register write strobe");
  AST_COLLIDE: assert property (x_req && y_req && x_addr >= 16'h3800 &&
    x_addr <= 16'h3808 && y_addr >= 16'h3800 && y_addr <= 16'h3808 |=> periph_collision)
    else $error("collision not flagged");
  AST_X_MEM: assert property (x_req && !x_we && x_addr == 16'h0010
    |=> x_mem_req && !x_mem_we && x_mem_addr == 16'h0010) else $error("x memory read forward");
  AST_X_MEM_WR: assert property (x_req && x_we && x_addr == 16'h1000
    |=> x_mem_req && x_mem_we && x_mem_addr == 16'h1000 && x_mem_wdata == $past(x_wdata))
    else $error("x memory write forward");
  AST_Y_MEM: assert property (y_req && y_addr == 16'h1000
    |=> y_mem_req && y_mem_addr == 16'h1000) else $error("y memory forward");
  AST_Y_MEM_WR: assert property (y_req && y_we && y_addr == 16'h1000
    |=> y_mem_we && y_mem_wdata == $past(y_wdata)) else $error("y memory write forward");
  AST_RSVD: assert property (x_req && x_addr == 16'h3809
    |=> data_reserved && periph_sel == 8'h00) else $error("reserved access selected");
endmodule : dam_decoder_chk

bind dam_decoder dam_decoder_chk u_chk (.ref_clk, .srst, .boot_done, .exec_start,
  .exec_addr, .serial_one_rx, .vector_valid, .vector_addr, .fetch_req, .fetch_addr,
  .imem_req, .imem_region, .fetch_reserved, .imem_addr, .x_req, .x_we, .x_addr, .x_wdata,
  .y_req, .y_we, .y_addr, .y_wdata, .x_mem_req, .x_mem_we, .x_mem_addr, .x_mem_wdata,
  .y_mem_req, .y_mem_we, .y_mem_addr, .y_mem_wdata, .periph_sel, .periph_we, .periph_wdata,
  .data_reserved, .periph_collision);

// *** verification/dam_core_model.sv ***
`timescale 1ns/1ps
module dam_core_model import dam_pkg::*; (
  // Clock.
  input wire logic ref_clk,
  // Fetch side.
  output logic fetch_req,
  output logic [15:0] fetch_addr,
  input wire logic imem_req,
  input wire logic [2:0] imem_region,
  input wire logic fetch_reserved,
  // Data side.
  output logic x_req,
  output logic x_we,
  output logic [15:0] x_addr,
  output logic [15:0] x_wdata,
  output logic y_req,
  output logic y_we,
  output logic [15:0] y_addr,
  output logic [15:0] y_wdata,
  input wire logic x_rvalid,
  input wire logic [15:0] x_rdata,
  input wire logic y_rvalid,
  input wire logic [15:0] y_rdata
);
  initial begin
    {fetch_req, x_req, x_we, y_req, y_we} = '0;
    {fetch_addr, x_addr, x_wdata, y_addr, y_wdata} = '0;
  end
  task automatic fetch(input logic [15:0] a, output logic q, output logic [2:0] r,
                       output logic s);
    @(posedge ref_clk);
    fetch_req <= 1'b1;
    // The vector region counts as loaded, unused slots as error branches.
    fetch_addr <= a;
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    fetch_addr <= ~a;
    @(negedge ref_clk);
    q = imem_req;
    r = imem_region;
    s = fetch_reserved;
  endtask : fetch
  // Reserved places and both spaces at once are reached only when a caller asks.
  task automatic acc(input logic [1:0] sp, input logic we, input logic [15:0] ax, ay, d,
                     output logic [15:0] rx, ry);
    rx = 'x;
    ry = 'x;
    @(posedge ref_clk);
    {x_req, x_we, x_addr, x_wdata} <= {sp[0], we, ax, d};
    {y_req, y_we, y_addr, y_wdata} <= {sp[1], we, ay, d};
    @(posedge ref_clk);
    // Released lines show the inverse so that no stale value passes.
    {x_req, x_addr, x_wdata} <= {1'b0, ~ax, ~d};
    {y_req, y_addr, y_wdata} <= {1'b0, ~ay, ~d};
    repeat (4) begin
      @(negedge ref_clk);
      if (x_rvalid === 1'b1) rx = x_rdata;
      if (y_rvalid === 1'b1) ry = y_rdata;
    end
  endtask : acc
endmodule : dam_core_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb_top;
  localparam logic [15:0] FA [7] = '{16'h0000, 16'h0150, 16'h0200, 16'h023F, 16'h0240,
                                     16'h4000, 16'hC000};
  localparam logic [3:0] FE [7] = '{4'h0, 4'h8, 4'h2, 4'h2, 4'h3, 4'h4, 4'h8};
  localparam logic [1:0] DS [6] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2};
  localparam logic [15:0] DA [6] = '{16'h3805, 16'h3805, 16'h0010, 16'h1000, 16'h3809,
                                     16'h3808};
  localparam logic [15:0] DX [6] = '{16'hA005, 16'hA005, 16'h1234, 16'h5678, 16'h0000,
                                     16'h0005};
  logic ref_clk, srst, boot_done;
  logic [9:0] ev;
  logic [15:0] x_mem_rdata, y_mem_rdata, rx, ry;
  logic [127:0] periph_rdata;
  int err_count = 0, num_checks = 0, cyc = 0;
  wire fetch_req, x_req, x_we, y_req, y_we, x_rvalid, y_rvalid, exec_start, vector_valid;
  wire imem_req, fetch_reserved;
  wire [15:0] fetch_addr, x_addr, x_wdata, y_addr, y_wdata, x_rdata, y_rdata, exec_addr;
  wire [15:0] vector_addr, data_wait_cycles;
  wire [2:0] imem_region;
  wire [7:0] periph_sel;
  dam_decoder DUT (.ref_clk, .srst, .boot_done, .exec_start, .exec_addr,
    .external_irq_one(ev[0]), .external_irq_two(ev[1]), .external_irq_three(ev[2]),
    .external_irq_four(ev[3]), .serial_one_rx(ev[4]), .serial_one_tx(ev[5]),
    .serial_two_rx(ev[6]), .serial_two_tx(ev[7]), .host_rx(ev[8]), .host_tx(ev[9]),
    .vector_valid, .vector_addr, .fetch_req, .fetch_addr, .imem_req, .imem_region,
    .imem_addr(), .fetch_reserved, .x_req, .x_we, .x_addr, .x_wdata, .x_rvalid, .x_rdata,
    .x_mem_req(), .x_mem_we(), .x_mem_addr(), .x_mem_wdata(), .x_mem_rdata, .y_req,
    .y_we, .y_addr, .y_wdata, .y_rvalid, .y_rdata, .y_mem_req(), .y_mem_we(),
    .y_mem_addr(), .y_mem_wdata(), .y_mem_rdata, .periph_sel, .periph_we(),
    .periph_wdata(), .periph_rdata, .data_wait_cycles, .data_reserved(),
    .periph_collision());
  dam_core_model core (.ref_clk, .fetch_req, .fetch_addr, .imem_req, .imem_region,
    .fetch_reserved, .x_req, .x_we, .x_addr, .x_wdata, .y_req, .y_we, .y_addr, .y_wdata,
    .x_rvalid, .x_rdata, .y_rvalid, .y_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // The ceiling is far above the roughly 125 cycles the tests need.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      final_report;
    end
  end
  task automatic t_boot;
    @(posedge ref_clk) ev <= 10'h010;
    repeat (4) @(negedge ref_clk);
    `CHK("masked vector", 1'b0, vector_valid)
    `CHK("wait reg reset", 16'h0000, data_wait_cycles)
    @(posedge ref_clk) {boot_done, ev} <= {1'b1, 10'h000};
    // The start pulse is due one edge after boot_done is seen, and lasts one cycle.
    repeat (2) @(negedge ref_clk);
    `CHK("exec start", 1'b1, exec_start)
    `CHK("exec addr", 16'h0200, exec_addr)
    @(negedge ref_clk);
    `CHK("exec start pulse", 1'b0, exec_start)
    $display("boot test done");
  endtask : t_boot
  // Host output stays pending throughout, so every step but the last also tests that the lowest wins.
  task automatic t_vec;
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk) ev <= (10'h001 << i) | 10'h200;
      repeat (4) @(negedge ref_clk);
      `CHK("vector valid", 1'b1, vector_valid)
      `CHK("vector addr", 16'h0210 + 16'(4 * i), vector_addr)
    end
    @(posedge ref_clk) ev <= 10'h000;
    $display("vector test done");
  endtask : t_vec
  task automatic t_fetch;
    logic q, s;
    logic [2:0] r;
    for (int i = 0; i < 7; i++) begin
      core.fetch(FA[i], q, r, s);
      `CHK("fetch forward", {!FE[i][3], FE[i][3]}, {q, s})
      if (!FE[i][3]) `CHK("fetch region", FE[i][2:0], r)
    end
    $display("fetch test done");
  endtask : t_fetch
  task automatic t_data;
    core.acc(2'h1, 1'b1, 16'h3808, 16'h3808, 16'h0005, rx, ry);
    `CHK("wait reg", 16'h0005, data_wait_cycles)
    // Both spaces write memory together; the checker watches the forwarded strobes.
    core.acc(2'h3, 1'b1, 16'h1000, 16'h1000, 16'h00C3, rx, ry);
    for (int i = 0; i < 6; i++) begin
      core.acc(DS[i], 1'b0, DA[i], DA[i], 16'h0000, rx, ry);
      `CHK("data read", DX[i], DS[i][0] ? rx : ry)
    end
    core.acc(2'h3, 1'b0, 16'h3801, 16'h3803, 16'h0000, rx, ry);
    `CHK("x wins", 16'hA001, rx)
    `CHK("y dropped", 16'h0000, ry)
    $display("data test done");
  endtask : t_data
  // A reset in mid-run must clear the wait register and wait for boot again.
  task automatic t_reset;
    @(posedge ref_clk) {srst, boot_done, ev} <= {1'b1, 1'b0, 10'h010};
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK("reset wait reg", 16'h0000, data_wait_cycles)
    `CHK("reset no start", 1'b0, exec_start)
    `CHK("reset masked vector", 1'b0, vector_valid)
    @(posedge ref_clk) {boot_done, ev} <= {1'b1, 10'h000};
    repeat (2) @(negedge ref_clk);
    `CHK("restart", 1'b1, exec_start)
    `CHK("restart addr", 16'h0200, exec_addr)
    $display("reset test done");
  endtask : t_reset
  initial begin
    {srst, boot_done, ev} = {1'b1, 1'b0, 10'h000};
    {x_mem_rdata, y_mem_rdata} = {16'h1234, 16'h5678};
    for (int i = 0; i < 8; i++) periph_rdata[16 * i +: 16] = 16'hA000 + 16'(i);
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    t_boot;
    t_vec;
    t_fetch;
    t_data;
    t_reset;
    final_report;
  end
endmodule : tb_top
